// ---- src/i2sac_top.sv ----
// Purpose: APB-programmed serial audio controller with transmit and receive FIFOs
// Assumes: Single clock; codec is slave to our bit and word clocks
// Notes: Serial input is synchronised by two flops before use
//
// Behaviour
// - Registers are reached through an APB slave port.
// - Control at 0x000 resets to 0x2200; bits 0..3 are enables.
// - Transmit alert when free transmit slots exceed watermark bits 10:8.
// - Receive alert when free receive slots are below watermark bits 14:12.
// - Control bit 17 drives codec reset pin; bit 16 flushes FIFOs.
// - Status at 0x004 shows full, empty and alert flags; resets 0x15.
// - Alert flags come from live FIFO levels against watermarks.
// - Error bit 1 flags receive overrun until software writes one.
// - Writing 0x010 pushes one word into the transmit FIFO.
// - Reading 0x014 pops one word from the receive FIFO.
// - Divide ratio register at 0x00C sets bit and word clock rates.
// - Test control at 0x300 enables integration test mode.
// - Test input at 0x304 returns the sampled serial input line.
// - Test output at 0x308 drives interrupt, clocks and data in test mode.
// - Error bit 0 flags transmit underrun, cleared by writing one.
// - Divider bits 9:0 reset to 0x20 and set the bit clock division.
// - Transmit words carry left in 31:16 and right in 15:0.
// - Receive words return left in 31:16 and right in 15:0.
`timescale 1ns/1ps
`default_nettype none
`include "i2sac_cfg.svh"
module i2sac_top #(
	parameter int DEPTH = 16,
	parameter logic [7:0] ID_BYTE = 8'h5a
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_in_line,
	output logic serial_out_line,
	output logic word_select_clock,
	output logic bit_clock,
	output logic codec_reset,
	output logic interrupt_line
);
	localparam int AW = $clog2(DEPTH);
	// ID_BYTE is an arbitrary neutral value
	typedef struct packed {
		logic [31:0] ctrl;
		logic [1:0] err;
		logic [9:0] div;
		logic test_mode_control;
		logic [3:0] itop;
		logic [9:0] divCnt;
		logic [4:0] bitIdx;
		logic lr;
		logic sclk;
		logic [31:0] txSh;
		logic [31:0] rxSh;
		logic sdo;
		logic [31:0] rdata;
		logic syn1;
		logic syn2;
		logic irq;
	} i2sac_state_all_t;
	i2sac_state_all_t s_q, s_d;
	logic wrEn, rdEn, txPush, rxPop, txPop, rxPush, flush;
	logic txValid, txReady, rxValid, rxReady, rxInReady;
	logic [31:0] txData, rxData;
	logic [AW:0] txLevel, rxLevel;
	logic txAlert, rxAlert, fall, wordEnd;
	i2sac_pkg::i2sac_sample_t rxWord;
	function automatic logic [AW:0] freeSlots(input logic [AW:0] lvl);
		freeSlots = (AW+1)'(DEPTH) - lvl;
	endfunction : freeSlots
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && penable && !pwrite;
	assign txPush = wrEn && paddr == `I2SAC_OFF_TXP;
	assign rxPop = rdEn && paddr == `I2SAC_OFF_RXP;
	assign flush = s_q.ctrl[`I2SAC_B_FRST];
	assign txAlert = freeSlots(txLevel) > (AW+1)'(s_q.ctrl[10:8]);
	assign rxAlert = freeSlots(rxLevel) < (AW+1)'(s_q.ctrl[14:12]);
	i2sac_fifo #(.WIDTH(32), .DEPTH(DEPTH)) txFifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.flush(flush),
		.inValid(txPush),
		.inReady(txReady),
		.inData(pwdata),
		.outValid(txValid),
		.outReady(txPop),
		.outData(txData),
		.level(txLevel)
	);
	i2sac_fifo #(.WIDTH(32), .DEPTH(DEPTH)) rxFifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.flush(flush),
		.inValid(rxPush),
		.inReady(rxInReady),
		.inData(rxWord),
		.outValid(rxValid),
		.outReady(rxPop),
		.outData(rxData),
		.level(rxLevel)
	);
	assign rxReady = rxInReady;
	// Bit clock toggles at each divider wrap; data changes on falling edge
	assign fall = s_q.divCnt == '0 && s_q.sclk;
	assign wordEnd = fall && s_q.bitIdx == 5'h1f;
	assign txPop = wordEnd && s_q.ctrl[`I2SAC_B_TXEN] && txValid;
	assign rxPush = wordEnd && s_q.ctrl[`I2SAC_B_RXEN] && !s_q.test_mode_control;
	always_comb begin
		rxWord.left = s_q.rxSh[31:16];
		rxWord.right = s_q.rxSh[15:0];
	end
	always_comb begin
		s_d = s_q;
		s_d.syn1 = serial_in_line;
		s_d.syn2 = s_q.syn1;
		if (wrEn) begin
			case (paddr)
				`I2SAC_OFF_CTRL: s_d.ctrl = pwdata & `I2SAC_CTRL_MASK;
				`I2SAC_OFF_DIV: s_d.div = pwdata[9:0];
				`I2SAC_OFF_TEST_MODE_CONTROL: s_d.test_mode_control = pwdata[0];
				`I2SAC_OFF_ITOP: s_d.itop = pwdata[3:0];
				default: ;
			endcase
		end
		if (wrEn && paddr == `I2SAC_OFF_ERR) begin
			s_d.err = s_q.err & ~pwdata[1:0];
		end
		// Serial engine, 32 bits per frame, left first
		if (s_q.divCnt == '0) begin
			s_d.divCnt = (s_q.div == '0) ? 10'h000 : s_q.div - 10'h001;
			s_d.sclk = !s_q.sclk;
			if (!s_q.sclk) begin
				s_d.rxSh = {s_q.rxSh[30:0], s_q.syn2};
			end else begin
				s_d.bitIdx = s_q.bitIdx + 5'h01;
				s_d.sdo = s_q.txSh[31];
				s_d.txSh = {s_q.txSh[30:0], 1'b0};
				if (s_q.bitIdx == 5'h0f) s_d.lr = 1'b1;
				if (s_q.bitIdx == 5'h1f) begin
					s_d.lr = 1'b0;
					if (txPop) s_d.txSh = txData;
					else s_d.txSh = '0;
					if (s_q.ctrl[`I2SAC_B_TXEN] && !txValid) s_d.err[`I2SAC_B_TXOVR] = 1'b1;
					if (rxPush && !rxReady) s_d.err[`I2SAC_B_RXOVR] = 1'b1;
				end
			end
		end else begin
			s_d.divCnt = s_q.divCnt - 10'h001;
		end
		s_d.rdata = '0;
		if (rdEn) begin
			case (paddr)
				`I2SAC_OFF_CTRL: s_d.rdata = s_q.ctrl;
				`I2SAC_OFF_STAT: s_d.rdata = {26'h0, !rxReady, !rxValid, !txReady, !txValid, rxAlert, txAlert};
				`I2SAC_OFF_ERR: s_d.rdata = {30'h0, s_q.err};
				`I2SAC_OFF_DIV: s_d.rdata = {22'h0, s_q.div};
				`I2SAC_OFF_RXP: s_d.rdata = rxData;
				`I2SAC_OFF_TEST_MODE_CONTROL: s_d.rdata = {31'h0, s_q.test_mode_control};
				`I2SAC_OFF_ITIP: s_d.rdata = {31'h0, s_q.syn2};
				`I2SAC_OFF_ITOP: s_d.rdata = {28'h0, s_q.itop};
				`I2SAC_OFF_PID0, `I2SAC_OFF_PID1, `I2SAC_OFF_PID2, `I2SAC_OFF_PID3,
				`I2SAC_OFF_PID4, `I2SAC_OFF_CID0, `I2SAC_OFF_CID1, `I2SAC_OFF_CID2,
				`I2SAC_OFF_CID3: s_d.rdata = {24'h0, ID_BYTE};
				default: s_d.rdata = '0;
			endcase
		end
		s_d.irq = s_q.test_mode_control ? s_q.itop[3] :
			((txAlert && s_q.ctrl[`I2SAC_B_TXIE]) || (rxAlert && s_q.ctrl[`I2SAC_B_RXIE]));
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.ctrl <= `I2SAC_CTRL_RST;
			s_q.div <= `I2SAC_DIV_RST;
		end else begin
			s_q <= s_d;
		end
	end
	// Read data is combinational from current state so APB sees it in access phase
	always_comb begin
		prdata = '0;
		if (rdEn) begin
			case (paddr)
				`I2SAC_OFF_RXP: prdata = rxData;
				default: prdata = s_d.rdata;
			endcase
		end
	end
	assign codec_reset = s_q.ctrl[`I2SAC_B_CRST];
	assign serial_out_line = s_q.test_mode_control ? s_q.itop[0] : s_q.sdo;
	assign bit_clock = s_q.test_mode_control ? s_q.itop[1] : s_q.sclk;
	assign word_select_clock = s_q.test_mode_control ? s_q.itop[2] : s_q.lr;
	assign interrupt_line = s_q.irq;
endmodule : i2sac_top
`default_nettype wire

// ---- src/i2sac_cfg.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the audio controller
// Assumes: 32-bit word-aligned register map on the peripheral bus
// Notes: Included by the design; the package does not include it
`ifndef I2SAC_CFG_SVH
`define I2SAC_CFG_SVH
`define I2SAC_OFF_CTRL 12'h000
`define I2SAC_OFF_STAT 12'h004
`define I2SAC_OFF_ERR 12'h008
`define I2SAC_OFF_DIV 12'h00c
`define I2SAC_OFF_TXP 12'h010
`define I2SAC_OFF_RXP 12'h014
`define I2SAC_OFF_TEST_MODE_CONTROL 12'h300
`define I2SAC_OFF_ITIP 12'h304
`define I2SAC_OFF_ITOP 12'h308
`define I2SAC_OFF_PID4 12'hfd0
`define I2SAC_OFF_PID0 12'hfe0
`define I2SAC_OFF_PID1 12'hfe4
`define I2SAC_OFF_PID2 12'hfe8
`define I2SAC_OFF_PID3 12'hfec
`define I2SAC_OFF_CID0 12'hff0
`define I2SAC_OFF_CID1 12'hff4
`define I2SAC_OFF_CID2 12'hff8
`define I2SAC_OFF_CID3 12'hffc
`define I2SAC_CTRL_RST 32'h0000_2200
`define I2SAC_CTRL_MASK 32'h0003_770f
`define I2SAC_STAT_RST 32'h0000_0015
`define I2SAC_DIV_RST 10'h020
`define I2SAC_B_TXEN 0
`define I2SAC_B_TXIE 1
`define I2SAC_B_RXEN 2
`define I2SAC_B_RXIE 3
`define I2SAC_B_FRST 16
`define I2SAC_B_CRST 17
`define I2SAC_B_TXOVR 0
`define I2SAC_B_RXOVR 1
`define I2SAC_SAMPLE_BITS 16
`endif

// ---- src/i2sac_pkg.sv ----
// Purpose: Types shared by the audio controller files
// Assumes: Constants come from i2sac_cfg.svh
// Notes: Types only
package i2sac_pkg;
	typedef struct packed {
		logic [15:0] left;
		logic [15:0] right;
	} i2sac_sample_t;
	typedef enum logic [3:0] {
		I2SAC_IDLE = 4'h1,
		I2SAC_LOAD = 4'h2,
		I2SAC_SHIFT = 4'h4,
		I2SAC_DONE = 4'h8
	} i2sac_state_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} i2sac_apb_req_t;
endpackage : i2sac_pkg

// ---- src/i2sac_fifo.sv ----
// Purpose: Word FIFO with valid and ready on both sides
// Assumes: Depth is a power of two
// Notes: Synchronous flush; level counts stored words
`timescale 1ns/1ps
`default_nettype none
module i2sac_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic flush,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData,
	output logic [AW:0] level
);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} i2sac_fifo_st_t;
	logic [WIDTH-1:0] mem [DEPTH];
	i2sac_fifo_st_t st_q, st_d;
	logic push, pop;
	// Full compare at the counter's own width; depth does not fit in AW bits
	assign inReady = st_q.cnt != (AW+1)'(DEPTH);
	assign outValid = st_q.cnt != '0;
	assign outData = mem[st_q.rp];
	assign level = st_q.cnt;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	always_comb begin
		st_d = st_q;
		if (push) st_d.wp = st_q.wp + AW'(1);
		if (pop) st_d.rp = st_q.rp + AW'(1);
		st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (flush) st_d = '0;
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) st_q <= '0;
		else st_q <= st_d;
	end
	always_ff @(posedge clock) begin
		if (push && !flush) mem[st_q.wp] <= inData;
	end
endmodule : i2sac_fifo
`default_nettype wire

// ---- tb/i2sac_props.sv ----
// Purpose: Port assertions of the audio controller
// Assumes: Zero-wait APB access phase
// Notes: Bound into every i2sac_top
`timescale 1ns/1ps
`default_nettype none
module i2sac_props (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic codec_reset
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic rdAcc;
	logic wrCtl;
	assign rdAcc = psel && penable && !pwrite;
	assign wrCtl = psel && penable && pwrite && paddr == 12'h000;
	ready_always_a: assert property (pready && !pslverr) else $error("bus answer wrong");
	rdata_idle_a: assert property (!rdAcc |-> prdata == 32'h0) else $error("read data outside access");
	codec_follow_a: assert property (wrCtl |=> codec_reset == $past(pwdata[17])) else $error("codec pin");
	codec_hold_a: assert property (!$stable(codec_reset) |-> $past(wrCtl)) else $error("codec pin moved");
	ctrl_rsvd_a: assert property (rdAcc && paddr == 12'h000 |-> (prdata & ~32'h0003_770f) == 32'h0)
		else $error("control reserved bits");
	stat_flags_a: assert property (rdAcc && paddr == 12'h004 |-> prdata[31:6] == 26'h0 && prdata[5:4] != 2'b11
		&& prdata[3:2] != 2'b11 && !(prdata[3] && prdata[0])) else $error("status flags");
	small_regs_a: assert property (rdAcc && paddr == 12'h008 |-> prdata[31:2] == 30'h0) else $error("error bits");
	div_bits_a: assert property (rdAcc && paddr == 12'h00c |-> prdata[31:10] == 22'h0) else $error("divider bits");
	unmapped_zero_a: assert property (rdAcc && paddr inside {12'h020, 12'h100} |-> prdata == 32'h0)
		else $error("unmapped read");
endmodule : i2sac_props
bind i2sac_top i2sac_props u_props (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .codec_reset);
`default_nettype wire

// ---- tb/i2sac_codec_model.sv ----
// Purpose: Codec model on the serial audio link
// Assumes: Codec is slave to the controller's clocks
// Notes: Answers with a scrambled echo of the transmit line
`timescale 1ns/1ps
`default_nettype none
module i2sac_codec_model (
	input wire logic bit_clock,
	input wire logic serial_out_line,
	output logic serial_in_line
);
	logic [15:0] lfsrQ = 16'hace1;
	assign serial_in_line = lfsrQ[15];
	// Change on falling edge, settled at rising
	always @(negedge bit_clock) begin
		lfsrQ <= {lfsrQ[14:0], lfsrQ[15] ^ lfsrQ[13] ^ serial_out_line};
	end
endmodule : i2sac_codec_model
`default_nettype wire

// ---- tb/i2s_audio_controller_tb.sv ----
// Purpose: Self-checking bench of the audio controller
// Assumes: DEPTH 16, codec model on the serial side
// Notes: Random words from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module i2s_audio_controller_tb;
	localparam int DEPTH = 16;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, v, w;
	logic pready, pslverr, serial_in_line, serial_out_line, word_select_clock, bit_clock, codec_reset, interrupt_line;
	int n_errors = 0;
	int total_checks = 0;
	int seed = 58574;
	int i;
	initial begin
		forever #25 clock = ~clock;
	end
	i2sac_top #(.DEPTH(DEPTH)) u_dut (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .serial_in_line, .serial_out_line, .word_select_clock, .bit_clock, .codec_reset, .interrupt_line);
	i2sac_codec_model u_codec (.bit_clock, .serial_out_line, .serial_in_line);
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		v = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, s);
			n_errors++;
		end
	endtask : chk
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, v);
	endtask : rc
	function automatic logic [31:0] txStat(input int n, input int wm);
		return {26'h0, 1'b0, 1'b1, n == DEPTH, n == 0, 1'b0, (DEPTH - n) > wm};
	endfunction : txStat
	task automatic results();
		if (n_errors == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	initial begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rc(12'h000, 32'h0000_2200);
		rc(12'h004, 32'h0000_0015);
		rc(12'h008, 32'h0);
		rc(12'h00c, 32'h20);
		xfer(1'b1, 12'h020, 32'hffff_ffff);
		rc(12'h020, 32'h0);
		rc(12'h100, 32'h0);
		xfer(1'b1, 12'h000, 32'hffff_ffff);
		rc(12'h000, 32'h0003_770f);
		chk("codec_reset", 1'b1, codec_reset);
		w = $random(seed);
		xfer(1'b1, 12'h00c, w);
		rc(12'h00c, {22'h0, w[9:0]});
		xfer(1'b1, 12'h000, 32'h2000 | {w[2:0], 8'h0});
		@(negedge clock);
		chk("codec_reset", 1'b0, codec_reset);
		for (i = 1; i <= DEPTH + 1; i++) begin
			xfer(1'b1, 12'h010, $random(seed));
			rc(12'h004, txStat(i > DEPTH ? DEPTH : i, w[2:0]));
		end
		xfer(1'b1, 12'h000, 32'h0001_2200);
		xfer(1'b1, 12'h000, 32'h0000_2202);
		rc(12'h004, 32'h15);
		chk("interrupt", 1'b1, interrupt_line);
		xfer(1'b1, 12'h300, 32'h1);
		xfer(1'b1, 12'h308, 32'hf);
		rc(12'h308, 32'hf);
		chk("test pins", 4'hf, {interrupt_line, word_select_clock, bit_clock, serial_out_line});
		rc(12'h304, {31'h0, serial_in_line});
		xfer(1'b1, 12'h300, 32'h0);
		xfer(1'b1, 12'h00c, 32'h1);
		xfer(1'b1, 12'h000, 32'h0000_2205);
		v = 32'h0;
		for (i = 0; i < 4000 && v[5] !== 1'b1; i++) xfer(1'b0, 12'h004, 32'h0);
		if (v[5] !== 1'b1) begin
			chk("receive full", 1'b1, v[5]);
			results();
		end
		repeat (800) @(posedge clock);
		xfer(1'b1, 12'h000, 32'h0000_2200);
		rc(12'h004, 32'h27);
		rc(12'h008, 32'h3);
		xfer(1'b1, 12'h008, 32'h1);
		rc(12'h008, 32'h2);
		xfer(1'b1, 12'h008, 32'h2);
		rc(12'h008, 32'h0);
		xfer(1'b0, 12'h014, 32'h0);
		rc(12'h004, 32'h07);
		xfer(1'b1, 12'h000, 32'h0000_2208);
		rc(12'h000, 32'h2208);
		chk("interrupt", 1'b1, interrupt_line);
		results();
	end
endmodule : i2s_audio_controller_tb
`default_nettype wire
